// ---- shared/acs_pkg.sv ----
package acs_pkg;
   // ==========================================================
   // Word widths
   localparam int          ACS_RES_W          = 16;
   localparam int          ACS_CFG_W          = 16;
   localparam int          ACS_CNT_W          = 8;

   // ==========================================================
   // Configuration word field positions
   localparam int          ACS_CFG_PHASE_BIT  = 0;
   localparam int          ACS_CFG_MODE_BIT   = 1;
   localparam int          ACS_CFG_REF_BIT    = 2;
   localparam int          ACS_CFG_GAIN_LSB   = 11;
   localparam int          ACS_CFG_GAIN_W     = 2;
   localparam int          ACS_CFG_CHAN_LSB   = 13;
   localparam int          ACS_CFG_CHAN_W     = 3;

   // Defaults: normal mode, internal reference, channel 0, lowest gain
   localparam logic [15:0] ACS_CFG_RST        = 16'h0006;
   localparam logic [15:0] ACS_RES_RST        = 16'h0000;

   // ==========================================================
   // Conversion phase lengths
   localparam int          ACS_CLK_PERIOD_NS  = 10;
   localparam int          ACS_SAFE_NS        = 500;
   localparam int          ACS_QUIET_FAST_NS  = 450;
   localparam int          ACS_QUIET_NORM_NS  = 500;
   localparam logic [7:0]  ACS_SAFE_CYC       =
      8'((ACS_SAFE_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS);
   localparam logic [7:0]  ACS_QUIET_FAST_CYC =
      8'((ACS_QUIET_FAST_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS);
   localparam logic [7:0]  ACS_QUIET_NORM_CYC =
      8'((ACS_QUIET_NORM_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS);

   // Serial frame: result then configuration readback
   localparam logic [4:0]  ACS_FRAME_LAST     = 5'h1f;
   localparam logic [3:0]  ACS_CFG_LAST_BIT   = 4'hf;

   // Conversion sequencer states
   typedef enum logic [1:0] {ACS_IDLE, ACS_SAFE, ACS_QUIET} acs_state_t;
endpackage

// ---- rtl/acs_conv_seq.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Sleep input high: deep sleep, starts ignored, serial interface inactive.
// - Rising sleep or reset input restores core and configuration defaults.
// - Configuration bit 1 picks mode: zero fast restricted, one normal.
// - Normal mode is default, no interval limit, host stays under 900 kSPS.
// - Quiet phase, hence busy time, is longer in normal mode.
// - Convert-start rising edge holds the sample and begins a conversion.
// - Further convert-start activity is ignored until the conversion ends.
// - Only sleep or reset inputs abort a running conversion.
// - Busy high covers a safe data-access phase then a quiet phase.
// - End of conversion is shown by busy falling low.
// - Unread result is overwritten at the next end of conversion.
// - Configuration word incomplete when chip select rises is discarded.
// - Configuration promoted at end of conversion through two stages, n+2.
// - Result readable immediately after its end of conversion.
// - Result shifts out while a 16-bit configuration word shifts in.
// - Configuration holds channel, gain and reference choice.
// - Output bit changes on serial clock falling edge; input captured on rising edge.
// - Rising sleep or reset aborts conversion and floats serial output.
// - With repeat select zero, MSB shows at chip select, then next bits.
// - Reset clears previous result so early reads return invalid data.
module acs_conv_seq
   import acs_pkg::*;
#(
   parameter int RES_W = ACS_RES_W
)
(
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             convert_start_input,
   input  wire logic             sleep_request_input,
   input  wire logic             device_reset_input,
   input  wire logic [RES_W-1:0] sample_code_in,
   input  wire logic             serial_clk,
   input  wire logic             chip_select_n,
   input  wire logic             serial_cfg_input,
   output logic                  busy,
   output logic                  result_valid,
   output logic                  conversion_mode_select,
   output logic [2:0]            active_channel,
   output logic [1:0]            active_gain,
   output logic                  active_ref_enable,
   output logic                  serial_result_output,
   output logic                  serial_result_output_oe
);

   // ==========================================================
   // Reset release and pin synchronisers
   logic             rst_meta_q;
   logic             rst_n_q;
   logic [4:0]       pin_raw;
   logic [4:0]       pin_meta_q;
   logic [4:0]       pin_sync_q;
   logic             cfg_tgl_q;

   // Two-flop release of the asynchronous reset
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Pins and the link toggle, all level crossings
   assign pin_raw = {cfg_tgl_q, ~chip_select_n, device_reset_input,
                     sleep_request_input, convert_start_input};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_sync
         always_ff @(posedge core_clk or negedge rst_n_q)
         begin
            if (!rst_n_q)
            begin
               pin_meta_q[gi] <= 1'b0;
               pin_sync_q[gi] <= 1'b0;
            end
            else
            begin
               pin_meta_q[gi] <= pin_raw[gi];
               pin_sync_q[gi] <= pin_meta_q[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Event decode
   logic             start_prev_q;
   logic             tgl_prev_q;
   logic             halt;
   logic             start_edge;
   logic             word_edge;

   assign halt       = pin_sync_q[1] | pin_sync_q[2];
   assign start_edge = pin_sync_q[0] & ~start_prev_q;
   assign word_edge  = pin_sync_q[4] ^ tgl_prev_q;

   // Edge history
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         start_prev_q <= 1'b0;
         tgl_prev_q   <= 1'b0;
      end
      else
      begin
         start_prev_q <= pin_sync_q[0];
         tgl_prev_q   <= pin_sync_q[4];
      end
   end

   // ==========================================================
   // Conversion sequencer
   acs_state_t       state_q;
   acs_state_t       state_d;
   logic [7:0]       cyc_q;
   logic [7:0]       cyc_d;
   logic [7:0]       quiet_len;
   logic             eoc;
   logic [15:0]      active_q;
   logic             conv_mode_q;
   logic [RES_W-1:0] sample_q;
   logic [RES_W-1:0] result_q;
   logic             valid_q;

   assign quiet_len = conv_mode_q ? ACS_QUIET_NORM_CYC : ACS_QUIET_FAST_CYC;
   assign eoc       = (state_q == ACS_QUIET) && (cyc_q == quiet_len - 8'h01) && !halt;

   // Next state: safe phase then quiet phase, starts ignored while busy
   always_comb
   begin
      state_d = state_q;
      cyc_d   = cyc_q + 8'h01;
      case (state_q)
         ACS_IDLE:
         begin
            cyc_d = 8'h00;
            if (start_edge && !halt)
               state_d = ACS_SAFE;
         end
         ACS_SAFE:
         begin
            if (cyc_q == ACS_SAFE_CYC - 8'h01)
            begin
               state_d = ACS_QUIET;
               cyc_d   = 8'h00;
            end
         end
         ACS_QUIET:
         begin
            if (eoc)
            begin
               state_d = ACS_IDLE;
               cyc_d   = 8'h00;
            end
         end
         default:
         begin
            state_d = ACS_IDLE;
            cyc_d   = 8'h00;
         end
      endcase
      if (halt)
      begin
         state_d = ACS_IDLE;
         cyc_d   = 8'h00;
      end
   end

   // Sequencer registers; mode and sample held for the whole conversion
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q     <= ACS_IDLE;
         cyc_q       <= 8'h00;
         conv_mode_q <= 1'b1;
         sample_q    <= RES_W'(ACS_RES_RST);
      end
      else
      begin
         state_q <= state_d;
         cyc_q   <= cyc_d;
         if (state_q == ACS_IDLE && state_d == ACS_SAFE)
         begin
            conv_mode_q <= active_q[ACS_CFG_MODE_BIT];
            sample_q    <= sample_code_in;
         end
      end
   end

   // Result register: overwritten at each end, cleared by device reset, kept through sleep
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         result_q <= RES_W'(ACS_RES_RST);
         valid_q  <= 1'b0;
      end
      else if (pin_sync_q[2])
      begin
         result_q <= RES_W'(ACS_RES_RST);
         valid_q  <= 1'b0;
      end
      else if (eoc)
      begin
         result_q <= sample_q;
         valid_q  <= 1'b1;
      end
   end

   // ==========================================================
   // Configuration pipeline
   logic [15:0]      cfg_hold_q;
   logic [15:0]      pending_q;
   logic             pending_vld_q;
   logic [15:0]      stage1_q;
   logic [15:0]      new_word;
   logic             new_vld;

   assign new_word = word_edge ? cfg_hold_q : pending_q;
   assign new_vld  = word_edge | pending_vld_q;

   // Pending kept apart from active; promoted only at end of conversion
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pending_q     <= ACS_CFG_RST;
         pending_vld_q <= 1'b0;
         stage1_q      <= ACS_CFG_RST;
         active_q      <= ACS_CFG_RST;
      end
      else if (halt)
      begin
         pending_q     <= ACS_CFG_RST;
         pending_vld_q <= 1'b0;
         stage1_q      <= ACS_CFG_RST;
         active_q      <= ACS_CFG_RST;
      end
      else if (eoc)
      begin
         pending_vld_q <= 1'b0;
         if (new_vld)
            stage1_q <= new_word;
         active_q <= stage1_q;
      end
      else if (word_edge)
      begin
         pending_q     <= cfg_hold_q;
         pending_vld_q <= 1'b1;
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         busy                    <= 1'b0;
         result_valid            <= 1'b0;
         conversion_mode_select  <= ACS_CFG_RST[ACS_CFG_MODE_BIT];
         active_channel          <= 3'h0;
         active_gain             <= 2'h0;
         active_ref_enable       <= ACS_CFG_RST[ACS_CFG_REF_BIT];
         serial_result_output_oe <= 1'b0;
      end
      else
      begin
         busy                    <= (state_d != ACS_IDLE);
         result_valid            <= valid_q;
         conversion_mode_select  <= active_q[ACS_CFG_MODE_BIT];
         active_channel          <= active_q[ACS_CFG_CHAN_LSB +: ACS_CFG_CHAN_W];
         active_gain             <= active_q[ACS_CFG_GAIN_LSB +: ACS_CFG_GAIN_W];
         active_ref_enable       <= active_q[ACS_CFG_REF_BIT];
         serial_result_output_oe <= pin_sync_q[3] & ~halt;
      end
   end

   // ==========================================================
   // Link side: serial shift on the serial clock
   logic [4:0]       out_idx_q;
   logic             repeat_done_q;
   logic [4:0]       in_cnt_q;
   logic [14:0]      in_shift_q;
   logic [31:0]      frame_word;

   assign frame_word = {result_q, active_q};

   // Output index: frame start shows MSB, falling edges advance
   always_ff @(negedge serial_clk or posedge chip_select_n)
   begin
      if (chip_select_n)
      begin
         out_idx_q     <= 5'h00;
         repeat_done_q <= 1'b0;
      end
      else
      begin
         repeat_done_q <= 1'b1;
         if (repeat_done_q || !active_q[ACS_CFG_PHASE_BIT])
            out_idx_q <= out_idx_q + 5'h01;
      end
   end

   // Result then configuration readback, most significant first
   assign serial_result_output = frame_word[ACS_FRAME_LAST - out_idx_q];

   // Input bit count per frame; a short frame never completes a word
   // Count stops after one word so extra bits in a frame are ignored
   always_ff @(posedge serial_clk or posedge chip_select_n)
   begin
      if (chip_select_n)
      begin
         in_cnt_q   <= 5'h00;
         in_shift_q <= 15'h0000;
      end
      else if (!halt && !in_cnt_q[4])
      begin
         in_cnt_q   <= in_cnt_q + 5'h01;
         in_shift_q <= {in_shift_q[13:0], serial_cfg_input};
      end
   end

   // Completed word handed over with a toggle
   always_ff @(posedge serial_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_hold_q <= ACS_CFG_RST;
         cfg_tgl_q  <= 1'b0;
      end
      else if (!chip_select_n && !halt && in_cnt_q == {1'b0, ACS_CFG_LAST_BIT})
      begin
         cfg_hold_q <= {in_shift_q, serial_cfg_input};
         cfg_tgl_q  <= ~cfg_tgl_q;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n_q);

   property p_sleep_no_start;
      halt |-> ##1 !busy;
   endproperty
   a_sleep_no_start: assert property (p_sleep_no_start) else $error("busy during halt");

   property p_defaults;
      halt |=> active_q == ACS_CFG_RST;
   endproperty
   a_defaults: assert property (p_defaults) else $error("config not defaulted");

   property p_mode_len;
      (state_q == ACS_QUIET && !halt && conv_mode_q && cyc_q < ACS_QUIET_NORM_CYC - 8'h01)
         |=> state_q == ACS_QUIET;
   endproperty
   a_mode_len: assert property (p_mode_len) else $error("normal quiet too short");

   property p_start;
      (state_q == ACS_IDLE && start_edge && !halt) |=> state_q == ACS_SAFE;
   endproperty
   a_start: assert property (p_start) else $error("start edge missed");

   property p_safe_len;
      (state_q == ACS_SAFE && !halt)
         |=> (state_q == ACS_QUIET) == ($past(cyc_q) == ACS_SAFE_CYC - 8'h01);
   endproperty
   a_safe_len: assert property (p_safe_len) else $error("safe phase short");

   property p_busy_end;
      eoc |=> !busy;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy not low at end");

   property p_result;
      eoc |=> result_q == $past(sample_q) && valid_q;
   endproperty
   a_result: assert property (p_result) else $error("result not loaded");

   property p_pipeline;
      (eoc && !new_vld) |=> stage1_q == $past(stage1_q) && active_q == $past(stage1_q);
   endproperty
   a_pipeline: assert property (p_pipeline) else $error("pipeline wrong");

   property p_hold;
      (!eoc && !pin_sync_q[2]) |=> $stable(result_q);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");

   property p_reset_clear;
      pin_sync_q[2] |=> !valid_q && result_q == RES_W'(ACS_RES_RST);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("result not cleared");

   c_conv:   cover property (eoc);
   c_abort:  cover property (state_q != ACS_IDLE && halt);
   c_word:   cover property (eoc && word_edge);
   c_serial: cover property (serial_result_output_oe && busy);

endmodule

// ---- sim/acs_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host side of the serial link
module acs_host_model
(
   output logic      serial_clk,
   output logic      chip_select_n,
   output logic      serial_cfg_input,
   input  wire logic serial_result_output
);
   localparam time HALF_NS = 24;

   // Link clock stands still low, device deselected
   initial
   begin
      serial_clk       = 1'b0;
      chip_select_n    = 1'b1;
      serial_cfg_input = 1'b0;
   end

   // One frame: word MSB first, output sampled on rising edges
   task automatic frame(input logic [15:0] cfg, input int nbits, output logic [31:0] rd);
      rd = 32'h0000_0000;
      chip_select_n = 1'b0;
      #(HALF_NS * 2);
      for (int i = 0; i < nbits; i++)
      begin
         serial_cfg_input = (i < 16) ? cfg[15 - i] : ~serial_cfg_input;
         #HALF_NS;
         serial_clk = 1'b1;
         if (i < 32)
         begin
            rd[31 - i] = serial_result_output;
         end
         #HALF_NS;
         serial_clk = 1'b0;
      end
      #HALF_NS;
      chip_select_n    = 1'b1;
      serial_cfg_input = ~serial_cfg_input; // Released line no longer holds data
   endtask
endmodule

// ---- sim/acs_conv_seq_bench.sv ----
`timescale 1ns/1ps
module acs_conv_seq_bench;
   import acs_pkg::*;
   // ==========================================================
   // Signals
   localparam int TIMEOUT_CYC = 20000;
   localparam int NORM_CYC    = int'(ACS_SAFE_CYC) + int'(ACS_QUIET_NORM_CYC);
   localparam int FAST_CYC    = int'(ACS_SAFE_CYC) + int'(ACS_QUIET_FAST_CYC);
   logic        core_clk;
   logic        arst_n;
   logic        convert_start_input;
   logic        sleep_request_input;
   logic        device_reset_input;
   logic [15:0] sample_code_in;
   logic        serial_clk;
   logic        chip_select_n;
   logic        serial_cfg_input;
   logic        busy;
   logic        result_valid;
   logic        conversion_mode_select;
   logic [2:0]  active_channel;
   logic [1:0]  active_gain;
   logic        active_ref_enable;
   logic        serial_result_output;
   logic        oe;
   logic [8:0]  stat;
   logic [31:0] rd;
   int          n;
   int          num_errors;
   int          samples_checked;
   int          cycle_count;

   // Status packed as busy, valid, mode, channel, gain, reference
   assign stat = {busy, result_valid, conversion_mode_select, active_channel, active_gain,
                  active_ref_enable};

   // ==========================================================
   // Design and host
   acs_conv_seq dut_u (
      .core_clk                (core_clk),
      .arst_n                  (arst_n),
      .convert_start_input     (convert_start_input),
      .sleep_request_input     (sleep_request_input),
      .device_reset_input      (device_reset_input),
      .sample_code_in          (sample_code_in),
      .serial_clk              (serial_clk),
      .chip_select_n           (chip_select_n),
      .serial_cfg_input        (serial_cfg_input),
      .busy                    (busy),
      .result_valid            (result_valid),
      .conversion_mode_select  (conversion_mode_select),
      .active_channel          (active_channel),
      .active_gain             (active_gain),
      .active_ref_enable       (active_ref_enable),
      .serial_result_output    (serial_result_output),
      .serial_result_output_oe (oe)
   );

   acs_host_model host_u (
      .serial_clk           (serial_clk),
      .chip_select_n        (chip_select_n),
      .serial_cfg_input     (serial_cfg_input),
      .serial_result_output (serial_result_output)
   );

   // ==========================================================
   // Tasks
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Counts and verdict
   task automatic print_verdict();
      $display("Errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One conversion; poke retriggers start mid-conversion; returns busy length
   task automatic convert(input logic [15:0] code, input bit poke, output int cyc);
      int w;
      w   = 0;
      cyc = 0;
      @(posedge core_clk);
      sample_code_in      <= code;
      convert_start_input <= 1'b1;
      repeat (3) @(posedge core_clk);
      convert_start_input <= 1'b0;
      #1;
      while (busy !== 1'b1 && w < 20)
      begin
         @(posedge core_clk);
         #1;
         w++;
      end
      while (busy === 1'b1 && cyc < 300)
      begin
         @(posedge core_clk);
         convert_start_input <= poke && cyc >= 10 && cyc < 13;
         #1;
         cyc++;
      end
      repeat (5) @(posedge core_clk);
   endtask

   // Start a conversion, then halt it by sleep or device reset
   task automatic abort_by(input bit use_sleep);
      @(posedge core_clk);
      convert_start_input <= 1'b1;
      repeat (30) @(posedge core_clk);
      convert_start_input <= 1'b0;
      sleep_request_input <= use_sleep;
      device_reset_input  <= !use_sleep;
      repeat (10) @(posedge core_clk);
      #1;
      check(32'(busy), 32'h0000_0000);
   endtask

   // ==========================================================
   // Clock and timeout
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial
   begin
      cycle_count = 0;
      forever
      begin
         @(posedge core_clk);
         cycle_count++;
         if (cycle_count == TIMEOUT_CYC)
         begin
            num_errors++;
            print_verdict();
         end
      end
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      num_errors          = 0;
      samples_checked     = 0;
      arst_n              = 1'b0;
      convert_start_input = 1'b0;
      sleep_request_input = 1'b0;
      device_reset_input  = 1'b0;
      sample_code_in      = 16'h0000;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      check(32'(stat), 32'h0000_0041);
      // Normal conversion with a retrigger while busy
      convert(16'ha5c3, 1'b1, n);
      check(32'(n), 32'(NORM_CYC));
      repeat (20) @(posedge core_clk);
      #1;
      check(32'(busy), 32'h0000_0000);
      check(32'(result_valid), 32'h0000_0001);
      fork
         host_u.frame(16'hb000, 32, rd);
         begin
            repeat (10) @(posedge core_clk);
            #1;
            check(32'(oe), 32'h0000_0001);
         end
      join
      check(rd, {16'ha5c3, ACS_CFG_RST});
      // New word reaches the active set only after two ends
      convert(16'h1234, 1'b0, n);
      check(32'(stat), 32'h0000_00c1);
      convert(16'h5678, 1'b0, n);
      check(32'(stat), 32'h0000_00ac);
      convert(16'h9abc, 1'b0, n);
      check(32'(n), 32'(FAST_CYC));
      // Short word dropped; unread result overwritten
      host_u.frame(16'h0006, 10, rd);
      convert(16'h1111, 1'b0, n);
      convert(16'h2222, 1'b0, n);
      check(32'(stat), 32'h0000_00ac);
      host_u.frame(16'h0007, 32, rd);
      check(rd, {16'h2222, 16'hb000});
      // Repeat select set: MSB shown twice
      convert(16'hc444, 1'b0, n);
      convert(16'h4c44, 1'b0, n);
      check(32'(stat), 32'h0000_00c1);
      host_u.frame(16'h0007, 32, rd);
      check(rd, {1'b0, 16'h4c44, 15'h0003});
      // Sleep halts, ignores starts and defaults the word
      abort_by(1'b1);
      @(posedge core_clk);
      convert_start_input <= 1'b1;
      repeat (20) @(posedge core_clk);
      convert_start_input <= 1'b0;
      #1;
      check(32'(busy), 32'h0000_0000);
      // Frame during sleep: output stays disabled with chip select low
      fork
         host_u.frame(16'hffff, 32, rd);
         begin
            repeat (10) @(posedge core_clk);
            #1;
            check(32'(oe), 32'h0000_0000);
         end
      join
      @(posedge core_clk);
      sleep_request_input <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      check(32'(stat), 32'h0000_00c1);
      // Host restores its word with two dummy conversions
      host_u.frame(16'hb000, 32, rd);
      convert(16'h0f0f, 1'b0, n);
      convert(16'hf0f0, 1'b0, n);
      check(32'(stat), 32'h0000_00ac);
      // Device reset clears result and word
      abort_by(1'b0);
      @(posedge core_clk);
      device_reset_input <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      check(32'(stat), 32'h0000_0041);
      host_u.frame(16'h0006, 32, rd);
      check(rd, {ACS_RES_RST, ACS_CFG_RST});
      print_verdict();
   end
endmodule
